/* File: fphs_host_model.sv */
// Host model: drives the alignment pin and decoded command pulses.
// Assumes commands arrive as one-cycle pulses on the master clock.
`default_nettype none
module fphs_host_model (
  input  wire logic clk_in,
  output var logic  align_pin_out,
  output var logic  align_cmd_out,
  output var logic  idle_cmd_out,
  output var logic  resume_cmd_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // Pin and commands idle low
  initial begin
    align_pin_out  = 1'b0;
    align_cmd_out  = 1'b0;
    idle_cmd_out   = 1'b0;
    resume_cmd_out = 1'b0;
  end
  // Rising edges gap cycles apart, started only after the mode is set
  task automatic pin_train(input int n, input int gap);
    repeat (n) begin
      @(posedge clk_in) align_pin_out <= 1'b1;
      repeat (gap / 2 - 1) @(posedge clk_in);
      @(posedge clk_in) align_pin_out <= 1'b0;
      repeat (gap - gap / 2 - 1) @(posedge clk_in);
    end
  endtask
  // One wire fans out, so every device sees the pulse at once
  task automatic cmd(input logic [1:0] kind);
    @(posedge clk_in);
    case (kind)
      2'h0: align_cmd_out <= 1'b1;
      2'h1: idle_cmd_out <= 1'b1;
      default: resume_cmd_out <= 1'b1;
    endcase
    @(posedge clk_in);
    align_cmd_out  <= 1'b0;
    idle_cmd_out   <= 1'b0;
    resume_cmd_out <= 1'b0;
  endtask
  // Gap must not be a whole number of conversion periods
  task automatic idle_resume(input int gap);
    cmd(2'h1);
    repeat (gap) @(posedge clk_in);
    cmd(2'h2);
  endtask
endmodule
`default_nettype wire

/* File: fphs_hpf.v */
// First-order high-pass IIR stage, the last filter section.
// Assumes one step pulse per conversion and a clear pulse on synchronization.
`default_nettype none
`include "fphs_regs.vh"
module fphs_hpf (
  input  wire               clk_in,
  input  wire               rst_n_in,
  input  wire               clear_in,
  input  wire               step_in,
  input  wire signed [23:0] sample_in,
  input  wire        [15:0] corner_in,
  output wire signed [23:0] result_out
);
  // Coefficient a is the corner word over 65536
  wire        [16:0] one_minus_a;  // (1 - a) in Q16
  wire        [33:0] oma_sq;       // (1 - a)^2 in Q32
  wire        [17:0] coef_b;       // b in Q16
  wire        [17:0] coef_g;       // (2 - a) / 2 in Q16
  reg  signed [23:0] prev_x;       // Previous input
  reg  signed [41:0] acc_y;        // Output state in Q16
  wire signed [24:0] diff_x;       // Input difference
  wire signed [60:0] fb_prod;      // b * y[n-1]
  wire signed [43:0] ff_prod;      // g * (x[n] - x[n-1])
  wire signed [41:0] next_acc_y;

  assign one_minus_a = `FPHS_Q16_ONE - {1'b0, corner_in};
  assign oma_sq      = one_minus_a * one_minus_a;
  // b = (1 + (1-a)^2) / 2, rounded down in Q16
  assign coef_b      = ({1'b0, `FPHS_Q16_ONE} + {1'b0, oma_sq[32:16]}) >> 1;
  assign coef_g      = (`FPHS_Q16_TWO - {2'b00, corner_in}) >> 1;
  assign diff_x      = {sample_in[23], sample_in} - {prev_x[23], prev_x};
  assign fb_prod     = $signed({1'b0, coef_b}) * acc_y;
  assign ff_prod     = $signed({1'b0, coef_g}) * diff_x;
  // Truncation toward minus infinity; a small dc residue is the trade for no rounder
  assign next_acc_y  = fb_prod[57:16] + ff_prod[41:0];
  assign result_out  = acc_y[39:16];

  // Recursion state; clear wipes the filter memory
  always @(posedge clk_in) begin
    if (!rst_n_in || clear_in) begin
      prev_x <= 24'h000000;
      acc_y  <= 42'h000000000;
    end else if (step_in) begin
      prev_x <= sample_in;
      acc_y  <= next_acc_y;
    end
  end
endmodule
`default_nettype wire

/* File: fphs_regs.vh */
// Constants for the phase select, high-pass and alignment control block.
// Assumes one 50 MHz clock and a register port with 3-bit word addresses.
`ifndef FPHS_REGS_VH
`define FPHS_REGS_VH
// Register word addresses
`define FPHS_ADDR_CONFIG   3'h0
`define FPHS_ADDR_HPF_LO   3'h1
`define FPHS_ADDR_HPF_HI   3'h2
`define FPHS_ADDR_PERIOD   3'h3
`define FPHS_ADDR_STATUS   3'h4
`define FPHS_ADDR_DATA     3'h5
// Config field positions
`define FPHS_CFG_PHASE     0
`define FPHS_CFG_CONT      1
`define FPHS_CFG_SINC      2
`define FPHS_CFG_RATE_LO   4
`define FPHS_CFG_RATE_HI   6
// Reset values
`define FPHS_CONFIG_RST    8'h00
`define FPHS_HPF_LO_RST    8'h37
`define FPHS_HPF_HI_RST    8'h03
`define FPHS_PERIOD_RST    16'hc350
// Sinc settle counts in master clock cycles, per rate code
`define FPHS_SINC_128K     24'h0001b8
`define FPHS_SINC_64K      24'h000268
`define FPHS_SINC_32K      24'h0003c8
`define FPHS_SINC_16K      24'h000688
`define FPHS_SINC_8K       24'h000b08
`define FPHS_RATE_128K     3'h0
`define FPHS_RATE_64K      3'h1
`define FPHS_RATE_32K      3'h2
`define FPHS_RATE_16K      3'h3
// Conversion periods before FIR output is valid
`define FPHS_FIR_SETTLE    6'h3f
// Zero-data periods after a continuous resync (valid on the 63rd)
`define FPHS_HOLD_PERIODS  6'h3e
// Cycles by which resume beats a synchronization
`define FPHS_RESUME_EARLY  24'h000002
// Fixed point: 1.0 and 2.0 in Q16
`define FPHS_Q16_ONE       17'h10000
`define FPHS_Q16_TWO       18'h20000
`define FPHS_Q16_SHIFT     16
`endif

/* File: fphs_top.v */
// Phase select, high-pass stage and conversion alignment control.
// Assumes the FIR stage sits upstream on sample_in and the serial port
// decodes commands into one-cycle pulses on this clock after the 8th bit.
`default_nettype none
`include "fphs_regs.vh"
// Notes on behaviour
// - Phase bit 0 linear, 1 minimum phase
// - Final stage is first-order high-pass IIR
// - Corner word is 16 bits over two registers
// - Corner word values set corner per rate
// - Align by pin or command, two modes
// - Pulse mode: every event restarts unconditionally
// - Sync clears filter, ready high until settled
// - Pin sync next edge; command after bit eight
// - Sinc settle counts 440 to 2824 cycles
// - Resume is two cycles faster than sync
// - Continuous: first edge syncs, then only misaligned
// - Continuous resync: ready toggles, data zero 62
// - Register write in continuous mode resyncs once the first edge is taken
// - Ready goes low on each new result
module fphs_top (
  input  wire        clk_in,
  input  wire        rst_n_in,
  input  wire  [2:0] addr_in,
  input  wire  [7:0] wdata_in,
  input  wire        wr_in,
  input  wire        rd_in,
  output reg   [7:0] rdata_out,
  input  wire        align_pin_in,
  input  wire        align_cmd_in,
  input  wire        idle_cmd_in,
  input  wire        resume_command_in,
  input  wire [23:0] sample_in,
  output wire        phase_select_out,
  output wire        filter_clear_out,
  output reg         conversion_ready_strobe_n_out,
  output reg  [23:0] data_out
);
  // One-hot conversion states
  localparam [2:0] ST_HALT   = 3'h1; // Stopped by idle
  localparam [2:0] ST_SETTLE = 3'h2; // Filter settling, ready held high
  localparam [2:0] ST_RUN    = 3'h4; // Results every period

  reg   [7:0] config_reg;      // Phase, mode, filter type, rate code
  reg   [7:0] hpf_lo;          // Corner word low byte
  reg   [7:0] hpf_hi;          // Corner word high byte
  reg  [15:0] period;          // Conversion period in cycles
  reg   [2:0] state;
  reg   [2:0] next_state;
  reg  [23:0] settle_left;     // Cycles until first result
  reg  [23:0] next_settle_left;
  reg  [15:0] conv_cnt;        // Position within conversion period
  reg  [15:0] edge_phase;      // Cycles since last pin edge, mod period
  reg   [5:0] hold_left;       // Zero-data periods still to go
  reg   [7:0] resync_count;    // Resyncs seen, for software
  reg         locked;          // First continuous edge taken
  reg         align_s1;        // Pin synchroniser, first stage
  reg         align_s2;        // Pin synchroniser, second stage
  reg         align_s3;        // Delayed copy for edge detect
  reg         tick_d;          // Result available next cycle
  wire        cont_mode;
  wire        sinc_mode;
  wire  [2:0] rate_code;
  wire        pin_rise;
  wire        pulse_sync;
  wire        cont_first;
  wire        cont_resync;
  wire        reg_wr_resync;
  wire        restart;
  wire        tick;
  wire [23:0] sinc_cycles;
  wire [23:0] fir_cycles;
  wire [23:0] settle_full;
  wire [23:0] hpf_result;

  assign cont_mode        = config_reg[`FPHS_CFG_CONT];
  assign sinc_mode        = config_reg[`FPHS_CFG_SINC];
  assign rate_code        = config_reg[`FPHS_CFG_RATE_HI:`FPHS_CFG_RATE_LO];
  assign phase_select_out = config_reg[`FPHS_CFG_PHASE];

  // Pin edge is only looked at after two flops
  assign pin_rise = align_s2 & ~align_s3;

  // Pulse mode takes pin and command alike; continuous takes only the pin
  assign pulse_sync    = !cont_mode && (pin_rise || align_cmd_in);
  assign cont_first    = cont_mode && pin_rise && !locked;
  // Misaligned edge: spacing not a whole number of periods
  assign cont_resync   = cont_mode && pin_rise && locked && (edge_phase != 16'h0000);
  // Any write in continuous mode, once the first edge is taken, throws the alignment away
  assign reg_wr_resync = cont_mode && wr_in && locked;
  // Full restart: stop, clear, settle again
  assign restart       = pulse_sync || cont_first;
  assign filter_clear_out = restart || cont_resync || reg_wr_resync;

  // Settle length by filter type and rate
  assign sinc_cycles = (rate_code == `FPHS_RATE_128K) ? `FPHS_SINC_128K :
                       (rate_code == `FPHS_RATE_64K)  ? `FPHS_SINC_64K  :
                       (rate_code == `FPHS_RATE_32K)  ? `FPHS_SINC_32K  :
                       (rate_code == `FPHS_RATE_16K)  ? `FPHS_SINC_16K  :
                       `FPHS_SINC_8K;
  // FIR needs a fixed number of whole periods
  assign fir_cycles  = {8'h00, period} * {18'h00000, `FPHS_FIR_SETTLE};
  assign settle_full = sinc_mode ? sinc_cycles : fir_cycles;

  // New conversion at the end of each period while running, and the first one
  // on the last settle cycle so ready falls right after the settle count.
  // A sync in the same cycle wins: the period restarts and no stale result is taken.
  assign tick = !filter_clear_out &&
                (((state == ST_RUN) && (conv_cnt == period - 16'h0001)) ||
                 ((state == ST_SETTLE) && (settle_left <= 24'h000001)));

  // Register writes; a write steers mode and the filter
  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      config_reg <= `FPHS_CONFIG_RST;
      hpf_lo     <= `FPHS_HPF_LO_RST;
      hpf_hi     <= `FPHS_HPF_HI_RST;
      period     <= `FPHS_PERIOD_RST;
    end else if (wr_in) begin
      case (addr_in)
        `FPHS_ADDR_CONFIG: config_reg <= wdata_in;
        `FPHS_ADDR_HPF_LO: hpf_lo <= wdata_in;
        `FPHS_ADDR_HPF_HI: hpf_hi <= wdata_in;
        `FPHS_ADDR_PERIOD: period <= {wdata_in, period[15:8]};
        default: ;
      endcase
    end
  end

  // Read data one cycle after the strobe; unmapped reads zero
  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      rdata_out <= 8'h00;
    end else if (rd_in) begin
      case (addr_in)
        `FPHS_ADDR_CONFIG: rdata_out <= config_reg;
        `FPHS_ADDR_HPF_LO: rdata_out <= hpf_lo;
        `FPHS_ADDR_HPF_HI: rdata_out <= hpf_hi;
        `FPHS_ADDR_PERIOD: rdata_out <= period[7:0];
        `FPHS_ADDR_STATUS: rdata_out <= {state, locked, (hold_left != 6'h00), 3'h0};
        `FPHS_ADDR_DATA:   rdata_out <= resync_count;
        default:           rdata_out <= 8'h00;
      endcase
    end else begin
      rdata_out <= 8'h00;
    end
  end

  // Pin synchroniser and edge history
  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      align_s1 <= 1'b0;
      align_s2 <= 1'b0;
      align_s3 <= 1'b0;
    end else begin
      align_s1 <= align_pin_in;
      align_s2 <= align_s1;
      align_s3 <= align_s2;
    end
  end

  // Interval since last pin edge, kept modulo the period
  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      edge_phase <= 16'h0000;
    end else if (pin_rise) begin
      edge_phase <= 16'h0001;
    end else if (edge_phase >= period - 16'h0001) begin
      edge_phase <= 16'h0000;
    end else begin
      edge_phase <= edge_phase + 16'h0001;
    end
  end

  // Conversion state selection
  always @* begin
    next_state       = state;
    next_settle_left = settle_left;
    case (state)
      ST_HALT: begin
        // Resume restarts two cycles ahead of a plain sync
        if (resume_command_in) begin
          next_state       = ST_SETTLE;
          next_settle_left = settle_full - `FPHS_RESUME_EARLY;
        end
      end
      ST_SETTLE: begin
        if (settle_left <= 24'h000001) begin
          next_state = ST_RUN;
        end else begin
          next_settle_left = settle_left - 24'h000001;
        end
      end
      ST_RUN: ;
      default: next_state = ST_SETTLE;
    endcase
    // Sync outranks everything; idle outranks a stale run
    if (restart) begin
      next_state       = ST_SETTLE;
      next_settle_left = settle_full;
    end else if (idle_cmd_in) begin
      next_state = ST_HALT;
    end
  end

  // Sequencer, period counter and continuous bookkeeping
  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      state        <= ST_SETTLE;
      settle_left  <= `FPHS_SINC_8K;
      conv_cnt     <= 16'h0000;
      hold_left    <= 6'h00;
      locked       <= 1'b0;
      resync_count <= 8'h00;
      tick_d       <= 1'b0;
    end else begin
      state       <= next_state;
      settle_left <= next_settle_left;
      tick_d      <= tick;
      // Period count restarts on any sync so ready stays periodic
      if (filter_clear_out || state != ST_RUN || tick) begin
        conv_cnt <= 16'h0000;
      end else begin
        conv_cnt <= conv_cnt + 16'h0001;
      end
      // Leaving continuous mode forgets the first edge
      if (!cont_mode) begin
        locked <= 1'b0;
      end else if (cont_first) begin
        locked <= 1'b1;
      end
      // Continuous resync keeps strobing but zeroes the data
      if (cont_resync || reg_wr_resync || restart) begin
        hold_left    <= (cont_resync || reg_wr_resync) ? `FPHS_HOLD_PERIODS : 6'h00;
        resync_count <= resync_count + 8'h01;
      end else if (tick_d && hold_left != 6'h00) begin
        hold_left <= hold_left - 6'h01;
      end
    end
  end

  // Ready strobe and result register
  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      conversion_ready_strobe_n_out <= 1'b1;
      data_out                      <= 24'h000000;
    end else if (restart || state != ST_RUN) begin
      conversion_ready_strobe_n_out <= 1'b1;
    end else if (tick_d) begin
      // Low marks a fresh result for the host
      conversion_ready_strobe_n_out <= 1'b0;
      data_out <= (hold_left != 6'h00) ? 24'h000000 : hpf_result;
    end else if (conv_cnt == {1'b0, period[15:1]}) begin
      // Half-period high time so the strobe visibly toggles
      conversion_ready_strobe_n_out <= 1'b1;
    end
  end

  // High-pass stage; memory cleared on every sync
  fphs_hpf u_hpf (
    .clk_in     (clk_in),
    .rst_n_in   (rst_n_in),
    .clear_in   (filter_clear_out),
    .step_in    (tick),
    .sample_in  (sample_in),
    .corner_in  ({hpf_hi, hpf_lo}),
    .result_out (hpf_result)
  );
endmodule
`default_nettype wire

/* File: fphs_top_bench.sv */
// Self-checking bench for the phase, high-pass and alignment block.
// Assumes the host model drives pin and commands; the bus is driven here.
`default_nettype none
module fphs_top_bench;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic w; logic [2:0] a; logic [7:0] d; logic [7:0] e; logic p;} fphs_row_t;
  logic        clk_in    = 1'b0;
  logic        rst_n_in  = 1'b0;
  logic [2:0]  addr_in   = 3'h0;
  logic [7:0]  wdata_in  = 8'h00;
  logic        wr_in     = 1'b0;
  logic        rd_in     = 1'b0;
  logic [23:0] sample_in = 24'h000000;
  logic [7:0]  rdata_out, rd_val;
  logic        align_pin_in, align_cmd_in, idle_cmd_in, resume_command_in;
  logic        phase_select_out, filter_clear_out, conversion_ready_strobe_n_out;
  logic [23:0] data_out;
  int          fails = 0, n_checks = 0, n_clr = 0, t, t_sync, base;
  fphs_row_t   rows [14];
  always #10 clk_in = ~clk_in; // 50 MHz
  // Ramp keeps the high-pass output away from zero
  always @(posedge clk_in) sample_in <= sample_in + 24'h000400;
  always @(posedge clk_in) if (filter_clear_out === 1'b1) n_clr <= n_clr + 1;
  fphs_top i_dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .addr_in(addr_in), .wdata_in(wdata_in),
    .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .align_pin_in(align_pin_in),
    .align_cmd_in(align_cmd_in), .idle_cmd_in(idle_cmd_in), .resume_command_in(resume_command_in),
    .sample_in(sample_in), .phase_select_out(phase_select_out), .filter_clear_out(filter_clear_out),
    .conversion_ready_strobe_n_out(conversion_ready_strobe_n_out), .data_out(data_out));
  fphs_host_model i_host (.clk_in(clk_in), .align_pin_out(align_pin_in), .align_cmd_out(align_cmd_in),
    .idle_cmd_out(idle_cmd_in), .resume_cmd_out(resume_command_in));
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_rng(input int n, input int lo, input int hi);
    n_checks++;
    if (n < lo || n > hi) begin
      fails++;
      $display("CHECK FAILED at %0t: count %0d outside %0d..%0d", $time, n, lo, hi);
    end
  endtask
  task automatic bus_wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_in);
    wr_in    <= 1'b1;
    addr_in  <= a;
    wdata_in <= d;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask
  task automatic bus_rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk_in);
    rd_in   <= 1'b1;
    addr_in <= a;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1 d = rdata_out;
  endtask
  // Edges until the next high-to-low step of ready; bounded
  task automatic wait_fall(output int n);
    logic prev;
    n = 0;
    #1;
    do begin
      prev = conversion_ready_strobe_n_out;
      @(posedge clk_in);
      #1 n++;
      if (n > 4000) begin
        fails++;
        wrap_up();
      end
    end while (!(prev === 1'b1 && conversion_ready_strobe_n_out === 1'b0));
  endtask
  initial begin
    rows = '{'{1'b0, 3'h1, 8'h00, 8'h37, 1'b0}, '{1'b0, 3'h2, 8'h00, 8'h03, 1'b0},
             '{1'b0, 3'h3, 8'h00, 8'h50, 1'b0}, '{1'b0, 3'h6, 8'h00, 8'h00, 1'b0},
             '{1'b1, 3'h0, 8'h01, 8'h00, 1'b1}, '{1'b1, 3'h7, 8'hff, 8'h00, 1'b1},
             '{1'b1, 3'h0, 8'h00, 8'h00, 1'b0}, '{1'b1, 3'h1, 8'h9a, 8'h00, 1'b0},
             '{1'b1, 3'h2, 8'h01, 8'h00, 1'b0}, '{1'b0, 3'h1, 8'h00, 8'h9a, 1'b0},
             '{1'b0, 3'h2, 8'h00, 8'h01, 1'b0}, '{1'b1, 3'h3, 8'h64, 8'h00, 1'b0},
             '{1'b1, 3'h3, 8'h00, 8'h00, 1'b0}, '{1'b0, 3'h3, 8'h00, 8'h64, 1'b0}};
    repeat (16) @(posedge clk_in);
    rst_n_in <= 1'b1;
    #1;
    chk(conversion_ready_strobe_n_out, 1'b1);
    foreach (rows[i]) begin
      if (rows[i].w) begin
        bus_wr(rows[i].a, rows[i].d);
        #1;
      end else begin
        bus_rd(rows[i].a, rd_val);
        chk(rd_val, rows[i].e);
      end
      chk(phase_select_out, rows[i].p);
    end
    // Pulse alignment on the fastest sinc rate, period now 100 cycles
    bus_wr(3'h0, 8'h04);
    base = n_clr;
    i_host.cmd(2'h0);
    wait_fall(t_sync);
    chk_rng(t_sync, 440, 442);
    chk_rng(n_clr - base, 1, 1);
    i_host.pin_train(1, 20);
    wait_fall(t);
    chk_rng(t + 20, 443, 447);
    i_host.idle_resume(37);
    wait_fall(t);
    chk_rng(t, t_sync - 2, t_sync - 2);
    // Continuous alignment: misplaced edges and register writes resynchronise, the align command does not
    bus_wr(3'h0, 8'h06);
    #1 base = n_clr;
    i_host.pin_train(4, 200);
    chk_rng(n_clr - base, 1, 1);
    i_host.pin_train(1, 150);
    i_host.pin_train(1, 2);
    repeat (3) @(posedge clk_in);
    for (int k = 1; k <= 63; k++) begin
      wait_fall(t);
      if (k > 1) chk_rng(t, 100, 100);
      if (k < 63) chk(data_out, 24'h000000);
      else chk(data_out === 24'h000000, 1'b0);
    end
    chk_rng(n_clr - base, 2, 2);
    base = n_clr;
    i_host.cmd(2'h0);
    repeat (3) @(posedge clk_in);
    #1 chk_rng(n_clr - base, 0, 0);
    bus_wr(3'h1, 8'h37);
    repeat (3) @(posedge clk_in);
    #1 chk_rng(n_clr - base, 1, 1);
    wrap_up();
  end
endmodule
bind fphs_top fphs_top_properties i_props (.clk_in(clk_in), .rst_n_in(rst_n_in), .addr_in(addr_in),
  .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .align_pin_in(align_pin_in),
  .align_cmd_in(align_cmd_in), .idle_cmd_in(idle_cmd_in), .resume_command_in(resume_command_in),
  .sample_in(sample_in), .phase_select_out(phase_select_out), .filter_clear_out(filter_clear_out),
  .conversion_ready_strobe_n_out(conversion_ready_strobe_n_out), .data_out(data_out));
`default_nettype wire

/* File: fphs_top_properties.sv */
// Concurrent checks for the phase, high-pass and alignment block.
// Assumes it is bound to fphs_top and sees only that module's ports.
`default_nettype none
module fphs_top_properties (
  input wire logic        clk_in,
  input wire logic        rst_n_in,
  input wire logic [2:0]  addr_in,
  input wire logic [7:0]  wdata_in,
  input wire logic        wr_in,
  input wire logic        rd_in,
  input wire logic [7:0]  rdata_out,
  input wire logic        align_pin_in,
  input wire logic        align_cmd_in,
  input wire logic        idle_cmd_in,
  input wire logic        resume_command_in,
  input wire logic [23:0] sample_in,
  input wire logic        phase_select_out,
  input wire logic        filter_clear_out,
  input wire logic        conversion_ready_strobe_n_out,
  input wire logic [23:0] data_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0]  cfg;   // Shadow of the config register
  logic [15:0] since; // Cycles since the last filter clear
  // Shadow config and age of the last clear
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      cfg   <= 8'h00;
      since <= 16'h0000;
    end else begin
      if (wr_in && addr_in == 3'h0) begin
        cfg <= wdata_in;
      end
      if (filter_clear_out) begin
        since <= 16'h0000;
      end else if (since != 16'hffff) begin
        since <= since + 16'h0001; // Saturates so long runs never wrap
      end
    end
  end
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  // Fastest sinc rate in pulse mode
  sequence s_fast_sinc;
    cfg[2:1] == 2'b10 && cfg[6:4] == 3'h0;
  endsequence
  // New result announced
  sequence s_ready_fall;
    $fell(conversion_ready_strobe_n_out);
  endsequence
  reset_quiet_a:
    assert property (disable iff (1'b0) !rst_n_in |=>
      conversion_ready_strobe_n_out && data_out == 24'h000000 && rdata_out == 8'h00)
    else $error("outputs not quiet after reset");
  cmd_sync_a:
    assert property (align_cmd_in && !cfg[1] |-> filter_clear_out)
    else $error("align command did not clear the filter");
  pin_sync_a:
    assert property ($rose(align_pin_in) && !cfg[1] |-> ##[1:3] filter_clear_out)
    else $error("pin edge did not clear the filter");
  phase_sel_a:
    assert property (phase_select_out == cfg[0])
    else $error("phase select differs from config");
  clear_ready_a:
    assert property (filter_clear_out && !cfg[1] |=> conversion_ready_strobe_n_out [*8])
    else $error("ready low right after a clear");
  settle_min_a:
    assert property (s_fast_sinc ##0 s_ready_fall |-> since >= 16'd437)
    else $error("ready fell before the sinc settle count");
  rdata_idle_a:
    assert property (!$past(rd_in) |-> rdata_out == 8'h00)
    else $error("read data without a read");
  rdata_unmapped_a:
    assert property (rd_in && addr_in > 3'h5 |=> rdata_out == 8'h00)
    else $error("unmapped read returned data");
endmodule
`default_nettype wire
